/* File: sar_adc_sequencer_ramp_counter.sv */
// Purpose: SAR start control, sequencer and bucket counter
// Assumes: Inputs synchronous to pclk
// Notes:   APB registers; one clock
//
// What this block does
// - Twelve-bit SAR result drives same-width DAC
// - Trial bits from MSB, driving each high-to-low
// - Keep bit low when DAC too high
// - One bit-clock period per trial, twelve total
// - Drive complete flag low after last trial
// - Result readable by controller over data bus
// - Start on routed start-request or bucket input
// - Drive select lines per mode encoding
// - Raise hold 15 us after start
// - Raise convert start 19 us after start
// - Hold high 18 us, convert 31 us
// - Done flag low 2 us after complete
// - Zero-span: 15 us pulses per bucket, sweeping
// - Normal mode sources pulse every 130/333 us
// - Noise bucket toggles peak selection in normal mode
// - Bucket counter counts 0 to 600
// - Count advances on each peak-reset enable pulse
// - Ramp compare rise marks bucket end
// - Bucket timing for swept or long zero-span
// - Odd-bucket output equals count LSB
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none

module sar_adc_sequencer_ramp_counter
    import sar_seq_pkg::*;
(
    input  wire logic                pclk,          // 10 MHz clock
    input  wire logic                presetn,       // Async reset, low
    input  wire logic                psel,          // APB select
    input  wire logic                penable,       // APB access phase
    input  wire logic                pwrite,        // APB write
    input  wire logic [7:0]          paddr,         // APB byte address
    input  wire logic [31:0]         pwdata,        // APB write data
    output logic      [31:0]         prdata,        // APB read data
    output logic                     pready,        // APB ready
    output logic                     pslverr,       // APB error
    input  wire logic                bit_clock_1mhz, // Trial clock
    input  wire logic                start_request, // Start source input
    input  wire logic                bucket_start,  // Bucket start input
    input  wire logic                zero_span_bucket_pulse, // Bucket tick
    input  wire logic                sweep_active,  // High during sweep
    input  wire logic                dac_high,      // Comparator: too high
    input  wire logic                noise_bucket,  // Noise detector flag
    input  wire logic                peak_reset_enable, // Counter advance
    input  wire logic                ramp_compare,  // Ramp passed DAC
    output logic      [RES_BITS-1:0] dac_code,      // SAR to DAC
    output logic      [RES_BITS-1:0] result,        // Latched result
    output logic                     track_hold_ctl, // Hold control
    output logic                     convert_start, // Conversion start
    output logic                     sar_complete_n, // SAR complete, low
    output logic                     conv_done_n,   // Done flag, low
    output start_select_t            start_select,  // Source select lines
    output logic                     zs_start_pulse, // Zero-span starts
    output logic                     tick_a,        // 130 us source
    output logic                     tick_b,        // 333 us source
    output logic                     negative_peak_mode, // Peak select
    output logic      [9:0]          bucket_count,  // Ramp counter
    output logic                     bucket_odd,    // Count LSB
    output logic                     bucket_end     // Bucket end pulse
);

    // ===================================================================
    // APB slave
    // ===================================================================
    logic [2:0]  ctrl;
    start_mode_t mode;
    wire         apb_access = psel & penable;
    wire         apb_wr     = apb_access & pwrite;
    wire         hit_ctrl   = (paddr == ADDR_CTRL);
    wire         hit_status = (paddr == ADDR_STATUS);
    wire         hit_result = (paddr == ADDR_RESULT);
    wire         hit_bucket = (paddr == ADDR_BUCKET);
    wire         hit_any    = hit_ctrl | hit_status | hit_result | hit_bucket;
    wire         long_zs    = ctrl[CTRL_LONG_ZS];
    logic [31:0] next_prdata;
    conv_state_t state;
    wire         busy       = (state != ST_IDLE);

    assign mode    = start_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);
    assign pready  = 1'b1;              // Zero-wait-state slave
    assign pslverr = apb_access & ~hit_any;

    // Read mux; result path acts as the data bus buffer
    assign next_prdata = hit_ctrl   ? {29'h0000_0000, ctrl} :
                         hit_status ? {28'h000_0000, negative_peak_mode,
                                       conv_done_n, sar_complete_n, busy} :
                         hit_result ? {20'h0_0000, result} :
                         hit_bucket ? {22'h00_0000, bucket_count} :
                         32'h0000_0000;

    // Read data loaded on a read setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= next_prdata;
        end
    end

    // Control register write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
        end else if (apb_wr & hit_ctrl) begin
            ctrl <= pwdata[2:0];
        end
    end

    // ===================================================================
    // Start-source selection
    // ===================================================================
    // Select encoding per mode: sel0/sel1
    assign start_select.sel0 = (mode == MODE_ZS_SAMPLE) |
                               (mode == MODE_SWEPT);
    assign start_select.sel1 = (mode == MODE_SWEPT) |
                               (mode == MODE_ALIGN);

    // Sel1 high routes the bucket input
    wire start_src = start_select.sel1 ? bucket_start
                                       : start_request;
    logic start_src_q;
    wire  start_evt = start_src & ~start_src_q;

    // Bit clock edge detect
    logic bclk_q;
    wire  bclk_rise = bit_clock_1mhz & ~bclk_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_src_q <= 1'b0;
            bclk_q      <= 1'b0;
        end else begin
            start_src_q <= start_src;
            bclk_q      <= bit_clock_1mhz;
        end
    end

    // ===================================================================
    // Conversion sequencer
    // ===================================================================
    logic [9:0] seq_timer;
    logic [4:0] settle_cnt;
    logic [3:0] bit_idx;
    logic       conv_seen;
    conv_state_t next_state;
    wire at_conv   = (seq_timer == CONV_ON_CYC);
    wire last_bit  = (bit_idx == 4'h0);
    wire trial_end = (state == ST_CONVERT) & conv_seen & bclk_rise;

    // Starts seen only in idle; busy starts dropped
    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE:    if (start_evt) next_state = ST_DELAY;
            ST_DELAY:   if (at_conv) next_state = ST_CONVERT;
            ST_CONVERT: if (trial_end & last_bit) next_state = ST_SETTLE;
            ST_SETTLE:  if (settle_cnt == DONE_CYC) next_state = ST_HOLDOFF;
            ST_HOLDOFF: if (seq_timer >= CONV_OFF_CYC)
                            next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Timer saturates so holdoff always ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_timer <= 10'h000;
        end else if (state == ST_IDLE) begin
            seq_timer <= 10'h000;
        end else if (seq_timer != 10'h3FF) begin
            seq_timer <= seq_timer + 10'h001;
        end
    end

    // Hold and convert windows timed from start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            track_hold_ctl <= 1'b0;
            convert_start  <= 1'b0;
        end else begin
            track_hold_ctl <= busy & (seq_timer >= HOLD_ON_CYC - 10'h001) &
                (seq_timer < HOLD_OFF_CYC - 10'h001);
            convert_start  <= busy & (seq_timer >= CONV_ON_CYC - 10'h001) &
                (seq_timer < CONV_OFF_CYC - 10'h001);
        end
    end

    // First bit clock rise arms the MSB, so each trial is a full period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_code  <= 12'h000;
            bit_idx   <= MSB_INDEX;
            conv_seen <= 1'b0;
        end else if (state == ST_DELAY) begin
            dac_code  <= 12'h000;
            bit_idx   <= MSB_INDEX;
            conv_seen <= 1'b0;
        end else if (state == ST_CONVERT & bclk_rise) begin
            if (!conv_seen) begin
                conv_seen          <= 1'b1;
                dac_code[MSB_INDEX] <= 1'b1;
            end else begin
                if (dac_high) begin
                    dac_code[bit_idx] <= 1'b0;
                end
                if (!last_bit) begin
                    dac_code[bit_idx - 4'h1] <= 1'b1;
                    bit_idx <= bit_idx - 4'h1;
                end
            end
        end
    end

    // Flags; result from final decision
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sar_complete_n <= 1'b1;
            conv_done_n    <= 1'b1;
            settle_cnt     <= 5'h00;
            result         <= 12'h000;
        end else begin
            if (state == ST_IDLE & start_evt) begin
                sar_complete_n <= 1'b1;
                conv_done_n    <= 1'b1;
            end
            if (trial_end & last_bit) begin
                sar_complete_n <= 1'b0;
                result <= {dac_code[RES_BITS-1:1],
                           dac_code[0] & ~dac_high};
            end
            settle_cnt <= (state == ST_SETTLE) ? settle_cnt + 5'h01 : 5'h00;
            if (state == ST_SETTLE & settle_cnt == DONE_CYC - 5'h01) begin
                conv_done_n <= 1'b0;
            end
        end
    end

    // Peak source toggles per noise bucket in normal mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            negative_peak_mode <= 1'b0;
        end else if (mode != MODE_NORMAL) begin
            negative_peak_mode <= 1'b0;
        end else if (trial_end & last_bit & noise_bucket) begin
            negative_peak_mode <= ~negative_peak_mode;
        end
    end

    // ===================================================================
    // Start pulse generators
    // ===================================================================
    logic [7:0]  zs_cnt;
    logic        zsb_q;
    logic [11:0] cnt_a;
    logic [11:0] cnt_b;
    // Bucket pulse used in zero-span sample only
    wire zs_fire = (mode == MODE_ZS_SAMPLE) & sweep_active &
                   zero_span_bucket_pulse & ~zsb_q;

    // One pulse per bucket tick; retrace cuts it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            zsb_q          <= 1'b0;
            zs_cnt         <= 8'h00;
            zs_start_pulse <= 1'b0;
        end else begin
            zsb_q <= zero_span_bucket_pulse;
            if (zs_fire) begin
                zs_cnt <= ZS_PULSE_CYC - 8'h01;
            end else if (zs_cnt != 8'h00) begin
                zs_cnt <= zs_cnt - 8'h01;
            end
            zs_start_pulse <= sweep_active &
                              (zs_fire | zs_cnt != 8'h00);
        end
    end

    // Normal mode sources; fixed width
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_a  <= 12'h000;
            cnt_b  <= 12'h000;
            tick_a <= 1'b0;
            tick_b <= 1'b0;
        end else if (mode != MODE_NORMAL) begin
            cnt_a  <= 12'h000;
            cnt_b  <= 12'h000;
            tick_a <= 1'b0;
            tick_b <= 1'b0;
        end else begin
            cnt_a  <= (cnt_a == TICK_A_CYC - 12'h001) ? 12'h000
                                                      : cnt_a + 12'h001;
            cnt_b  <= (cnt_b == TICK_B_CYC - 12'h001) ? 12'h000
                                                      : cnt_b + 12'h001;
            tick_a <= (cnt_a < TICK_W_CYC);
            tick_b <= (cnt_b < TICK_W_CYC);
        end
    end

    // ===================================================================
    // Bucket (ramp) counter
    // ===================================================================
    logic pre_q;
    logic ramp_q;
    // Swept or long zero-span sweeps
    wire  bucket_mode = (mode == MODE_SWEPT) |
                        (mode == MODE_ZS_SAMPLE & long_zs);
    wire  advance     = peak_reset_enable & ~pre_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q        <= 1'b0;
            ramp_q       <= 1'b0;
            bucket_count <= 10'h000;
            bucket_end   <= 1'b0;
        end else begin
            pre_q      <= peak_reset_enable;
            ramp_q     <= ramp_compare;
            bucket_end <= bucket_mode & ramp_compare & ~ramp_q;
            if (!bucket_mode) begin
                bucket_count <= 10'h000;
            end else if (advance) begin
                bucket_count <= (bucket_count == BUCKET_LAST) ? 10'h000
                              : bucket_count + 10'h001;
            end
        end
    end

    assign bucket_odd = bucket_count[0];

endmodule : sar_adc_sequencer_ramp_counter

`default_nettype wire

/* File: sar_seq_pkg.sv */
// Purpose: Shared constants and types for the converter sequencer
// Assumes: pclk at 10 MHz
// Notes:   Times in ns, turned into pclk cycles
package sar_seq_pkg;

    // ===================================================================
    // Clock and timing
    // ===================================================================
    localparam int CLK_MHZ          = 10;
    localparam int HOLD_DELAY_NS    = 15000;  // Start to hold rise
    localparam int CONV_DELAY_NS    = 19000;  // Start to convert rise
    localparam int HOLD_WIDTH_NS    = 18000;  // Hold high time
    localparam int CONV_WIDTH_NS    = 31000;  // Convert start high time
    localparam int DONE_DELAY_NS    = 2000;   // Complete to done
    localparam int ZS_PULSE_NS      = 15000;  // Zero-span start pulse
    localparam int TICK_A_NS        = 130000; // Normal mode source A
    localparam int TICK_B_NS        = 333000; // Normal mode source B
    localparam int TICK_WIDTH_NS    = 1000;   // Normal mode pulse width

    // Least times round up to whole cycles
    function automatic int ns_to_cyc(input int ns);
        return (ns * CLK_MHZ + 999) / 1000;
    endfunction : ns_to_cyc

    localparam logic [9:0]  HOLD_ON_CYC  = 10'(ns_to_cyc(HOLD_DELAY_NS));
    localparam logic [9:0]  CONV_ON_CYC  = 10'(ns_to_cyc(CONV_DELAY_NS));
    localparam logic [9:0]  HOLD_OFF_CYC =
        10'(ns_to_cyc(HOLD_DELAY_NS + HOLD_WIDTH_NS));
    localparam logic [9:0]  CONV_OFF_CYC =
        10'(ns_to_cyc(CONV_DELAY_NS + CONV_WIDTH_NS));
    localparam logic [4:0]  DONE_CYC     = 5'(ns_to_cyc(DONE_DELAY_NS));
    localparam logic [7:0]  ZS_PULSE_CYC = 8'(ns_to_cyc(ZS_PULSE_NS));
    localparam logic [11:0] TICK_A_CYC   = 12'(ns_to_cyc(TICK_A_NS));
    localparam logic [11:0] TICK_B_CYC   = 12'(ns_to_cyc(TICK_B_NS));
    localparam logic [11:0] TICK_W_CYC   = 12'(ns_to_cyc(TICK_WIDTH_NS));

    // ===================================================================
    // Converter and bucket counter
    // ===================================================================
    localparam int          RES_BITS     = 12;
    localparam logic [3:0]  MSB_INDEX    = 4'hB;
    localparam logic [9:0]  BUCKET_LAST  = 10'h258;  // 600

    // ===================================================================
    // Register map (byte addresses) and field positions
    // ===================================================================
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_STATUS  = 8'h04;
    localparam logic [7:0]  ADDR_RESULT  = 8'h08;
    localparam logic [7:0]  ADDR_BUCKET  = 8'h0C;
    localparam int          CTRL_MODE_LSB = 0;   // Two bits
    localparam int          CTRL_LONG_ZS  = 2;   // Zero-span sweep > 60 s
    localparam logic [2:0]  CTRL_RESET    = 3'h0;

    // Start-source selection modes
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_ZS_SAMPLE,
        MODE_SWEPT,
        MODE_ALIGN
    } start_mode_t;

    // Two start-source select lines
    typedef struct packed {
        logic sel0;
        logic sel1;
    } start_select_t;

    // Conversion sequence states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_DELAY,
        ST_CONVERT,
        ST_SETTLE,
        ST_HOLDOFF
    } conv_state_t;

endpackage : sar_seq_pkg

/* File: sar_seq_monitor.sv */
// Purpose: Timing checks for the converter sequencer
// Assumes: pclk 100 ns, bit clock 1 MHz
// Notes:   Windows allow for bit clock phase
`timescale 1ns/1ps
`default_nettype none
module sar_seq_monitor
    import sar_seq_pkg::*;
(
    input wire logic        pclk,           // Clock
    input wire logic        presetn,        // Reset, low
    input wire logic [11:0] dac_code,       // SAR trial code
    input wire logic        track_hold_ctl, // Hold control
    input wire logic        convert_start,  // Conversion start
    input wire logic        sar_complete_n, // Complete, low
    input wire logic        conv_done_n,    // Done, low
    input wire logic        bucket_end,     // Bucket end pulse
    input wire logic        bucket_odd,     // Count LSB
    input wire logic [9:0]  bucket_count    // Bucket counter
);
    // ==================================================================
    // Conversion sequence
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_hold_to_conv: assert property (
        $rose(track_hold_ctl) |-> ##40 $rose(convert_start))
        else $error("Convert start late");
    a_hold_width: assert property (
        $rose(track_hold_ctl) |-> ##179 track_hold_ctl ##1 !track_hold_ctl)
        else $error("Hold width wrong");
    a_conv_width: assert property (
        $rose(convert_start) |-> ##300 convert_start ##9 convert_start
        ##1 !convert_start) else $error("Convert start width wrong");
    a_msb_first: assert property (
        $rose(convert_start) |-> ##[1:15] (dac_code == 12'h800))
        else $error("MSB not first");
    a_sar_time: assert property (
        $rose(convert_start) |-> ##[115:140] $fell(sar_complete_n))
        else $error("Complete time wrong");
    a_done_delay: assert property (
        $fell(sar_complete_n) |-> ##[19:21] $fell(conv_done_n))
        else $error("Done delay wrong");
    // ==================================================================
    // Bucket counter
    a_odd_lsb: assert property (
        bucket_odd == bucket_count[0]) else $error("Odd flag not LSB");
    a_count_range: assert property (
        bucket_count <= BUCKET_LAST) else $error("Count above last");
    a_count_step: assert property (
        $changed(bucket_count) |-> bucket_count == 10'h000 ||
        bucket_count == $past(bucket_count) + 10'h001)
        else $error("Count step wrong");
    // Main scenarios reached
    c_done: cover property ($fell(conv_done_n));
    c_bend: cover property ($rose(bucket_end));
    c_last: cover property (bucket_count == BUCKET_LAST);
endmodule : sar_seq_monitor

bind sar_adc_sequencer_ramp_counter sar_seq_monitor i_mon (
    .pclk(pclk), .presetn(presetn), .dac_code(dac_code),
    .track_hold_ctl(track_hold_ctl), .convert_start(convert_start),
    .sar_complete_n(sar_complete_n), .conv_done_n(conv_done_n),
    .bucket_end(bucket_end), .bucket_odd(bucket_odd),
    .bucket_count(bucket_count));
`default_nettype wire

/* File: sar_far_side.sv */
// Purpose: Bit clock source and comparator
// Assumes: pclk 100 ns, so five cycles make a half bit period
// Notes:   vin is the held input level
`timescale 1ns/1ps
`default_nettype none
module sar_far_side
(
    input  wire logic        pclk,           // Clock
    input  wire logic [11:0] dac_code,       // Trial code
    input  wire logic [11:0] vin,            // Held input level
    output logic             bit_clock_1mhz, // Bit clock
    output logic             dac_high        // DAC above input
);
    logic [2:0] div = 3'h0;
    // Free-running, also in reset
    always @(posedge pclk) begin
        div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
        if (div == 3'h4) begin
            bit_clock_1mhz <= ~bit_clock_1mhz;
        end
    end
    initial bit_clock_1mhz = 1'b0;
    // Ideal comparator, no offset
    assign dac_high = (dac_code > vin);
endmodule : sar_far_side
`default_nettype wire

/* File: testbench.sv */
// Purpose: Bench for the converter sequencer
// Assumes: pclk 100 ns
// Notes:   One task per scenario
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sar_seq_pkg::*;
    logic          presetn, pclk, psel, penable, pwrite, err, pready;
    logic [7:0]    paddr;
    logic [31:0]   pwdata, prdata, rd;
    logic          pslverr, bclk, start_request, bucket_start, zsp, sweep;
    logic          dac_high, noise, pre, ramp, pick, tsel;
    logic [11:0]   dac_code, result, vin;
    logic          hold, conv, cmpl_n, done_n, zsp_out, tick_a, tick_b;
    logic          negpk, bodd, bend;
    logic [9:0]    bcount;
    start_select_t ssel;
    int            n_mismatch = 0;
    int            check_count = 0;
    assign tsel = pick ? tick_a : tick_b;
    // ==================================================================
    // Design and far side
    sar_adc_sequencer_ramp_counter i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bit_clock_1mhz(bclk),
        .start_request(start_request), .bucket_start(bucket_start),
        .zero_span_bucket_pulse(zsp), .sweep_active(sweep),
        .dac_high(dac_high), .noise_bucket(noise),
        .peak_reset_enable(pre), .ramp_compare(ramp), .dac_code(dac_code),
        .result(result), .track_hold_ctl(hold), .convert_start(conv),
        .sar_complete_n(cmpl_n), .conv_done_n(done_n),
        .start_select(ssel), .zs_start_pulse(zsp_out), .tick_a(tick_a),
        .tick_b(tick_b), .negative_peak_mode(negpk),
        .bucket_count(bcount), .bucket_odd(bodd), .bucket_end(bend));
    sar_far_side i_far (.pclk(pclk), .dac_code(dac_code), .vin(vin),
        .bit_clock_1mhz(bclk), .dac_high(dac_high));
    // ==================================================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    // Holds the request until pready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic pulse(input int n);
        repeat (n) begin
            pre <= 1'b1;
            tick(2);
            pre <= 1'b0;
            tick(2);
        end
    endtask : pulse
    task automatic results;
        $display("checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results
    // ==================================================================
    // Scenarios
    task automatic t_reset;
        check({hold, conv, cmpl_n, done_n, bcount}, 14'h0C00);
        apb(0, ADDR_CTRL, 32'h0);
        check(rd, {29'h0, CTRL_RESET});
        $display("reset done");
    endtask : t_reset
    task automatic t_modes;
        logic [1:0] m;
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            apb(1, ADDR_CTRL, 32'(m));
            #1 check(ssel, {m[0] ^ m[1], m[1]});
        end
        apb(0, 8'h10, 32'h0);
        check({err, rd[30:0]}, 32'h80000000);
        $display("mode done");
    endtask : t_modes
    // Wrong source, routed source held high, then both high while busy
    task automatic t_conv(input logic [1:0] m, input logic [11:0] v,
                          input logic nz);
        logic np;
        int   k;
        apb(1, ADDR_CTRL, 32'(m));
        {vin, noise} <= {v, nz};
        {start_request, bucket_start} <= {m[1], ~m[1]};
        tick(2);
        {start_request, bucket_start} <= 2'b00;
        tick(170);
        check(hold, 1'b0);
        np = negpk;
        {start_request, bucket_start} <= {~m[1], m[1]};
        tick(205);
        {start_request, bucket_start} <= 2'b11;
        tick(2);
        {start_request, bucket_start} <= 2'b00;
        k = 0;
        while (done_n !== 1'b0 && k < 1000) begin
            tick(1);
            k++;
        end
        tick(300);
        check(result, v);
        check({hold, conv, done_n}, 3'b000);
        check(negpk, (m == 2'(MODE_NORMAL)) ? np ^ nz : 1'b0);
        apb(0, ADDR_RESULT, 32'h0);
        check(rd[11:0], v);
        $display("conversion done");
    endtask : t_conv
    task automatic t_bucket;
        logic seen;
        apb(1, ADDR_CTRL, 32'(MODE_NORMAL));
        pulse(3);
        check(bcount, 10'h000);
        apb(1, ADDR_CTRL, 32'(MODE_SWEPT));
        pulse(599);
        check({bodd, bcount}, {1'b1, 10'h257});
        pulse(1);
        check(bcount, BUCKET_LAST);
        pulse(1);
        check(bcount, 10'h000);
        apb(1, ADDR_CTRL, 32'h5);
        pulse(1);
        check(bcount, 10'h001);
        ramp <= 1'b1;
        seen = 1'b0;
        repeat (3) begin
            tick(1);
            seen = seen | (bend === 1'b1);
        end
        ramp <= 1'b0;
        check(seen, 1'b1);
        $display("bucket done");
    endtask : t_bucket
    // Zero-span pulses in sweep only
    task automatic t_zs;
        int k;
        apb(1, ADDR_CTRL, 32'(MODE_ZS_SAMPLE));
        for (int s = 1; s >= 0; s--) begin
            sweep <= s[0];
            tick(2);
            zsp <= 1'b1;
            tick(1);
            zsp <= 1'b0;
            k = 0;
            repeat (200) begin
                tick(1);
                k += int'(zsp_out === 1'b1);
            end
            check(32'(k), s ? 32'(ZS_PULSE_CYC) : 32'h0);
        end
        $display("zero-span done");
    endtask : t_zs
    task automatic t_tick(input logic b);
        int k;
        apb(1, ADDR_CTRL, 32'(MODE_NORMAL));
        pick <= b;
        tick(1);
        k = 0;
        while (tsel !== 1'b1 && k < 4000) begin
            tick(1);
            k++;
        end
        k = 20;
        tick(20);
        while (tsel !== 1'b1 && k < 4000) begin
            tick(1);
            k++;
        end
        check(32'(k), 32'(b ? TICK_A_CYC : TICK_B_CYC));
        $display("tick done");
    endtask : t_tick
    // ==================================================================
    // Clock, sequence, watchdog
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, start_request, bucket_start} = '0;
        {zsp, sweep, noise, pre, ramp, pick} = '0;
        {paddr, pwdata, vin} = '0;
        tick(3);
        presetn <= 1'b1;
        tick(1);
        #1 t_reset;
        t_modes;
        t_conv(MODE_NORMAL, 12'hA5A, 1'b1);
        t_conv(MODE_NORMAL, 12'hFFF, 1'b1);
        t_conv(MODE_SWEPT, 12'h000, 1'b0);
        t_conv(MODE_ZS_SAMPLE, 12'h800, 1'b1);
        t_bucket;
        t_zs;
        t_tick(1'b1);
        t_tick(1'b0);
        results;
    end
    initial begin
        repeat (60000) @(posedge pclk);
        n_mismatch++;
        results;
    end
endmodule : testbench
`default_nettype wire
